// ### tmr_pkg.sv
package tmr_pkg;

  // Widths of the counter, the shared prescaler, its ratio field, the direction latch and the file address.
  localparam int TIMER_W = 8;
  localparam int PRESC_W = 8;
  localparam int RATIO_W = 3;
  localparam int TRIS_W = 4;
  localparam int ADDR_W = 5;

  // File register address of the timer count.
  localparam logic [ADDR_W-1:0] TIMER_COUNT_ADDR = 5'h01;

  // Reset values.
  localparam logic [TIMER_W-1:0] TIMER_RESET = 8'h00;
  localparam logic [7:0] OPTION_RESET = 8'hFF;
  localparam logic [TRIS_W-1:0] TRIS_RESET = 4'hF;
  localparam logic [PRESC_W-1:0] PRESC_RESET = 8'h00;

  // Position of the timer clock pin among the direction bits.
  localparam int PIN_CLK_IDX = 2;

  // Four oscillator periods form one instruction cycle, Q1 to Q4.
  localparam logic [1:0] PHASE_Q1 = 2'h0;
  localparam logic [1:0] PHASE_Q2 = 2'h1;
  localparam logic [1:0] PHASE_Q4 = 2'h3;
  localparam int CLK_PER_INSTR = 4;

  // Increment hold-off after a write, in instruction cycles and clocks.
  localparam int INHIBIT_INSTR = 2;
  localparam int INHIBIT_CLKS_I = INHIBIT_INSTR * CLK_PER_INSTR;
  localparam logic [3:0] INHIBIT_CLKS = 4'(INHIBIT_CLKS_I);

  // The system clock is the oscillator: one Tosc per clock.
  localparam int CLK_PERIOD_PS = 5000;
  localparam int TOSC_PS = 5000;
  localparam int EDGE_DELAY_MIN_TOSC = 3;
  localparam int EDGE_DELAY_MAX_TOSC = 7;
  localparam int EDGE_DELAY_MIN_CYC =
    (EDGE_DELAY_MIN_TOSC * TOSC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int EDGE_DELAY_MAX_CYC =
    (EDGE_DELAY_MAX_TOSC * TOSC_PS) / CLK_PERIOD_PS;

  // Option register layout, most significant bit first.
  typedef struct packed {
    logic wake_on_change_n;
    logic pullup_n;
    logic clock_source_select;
    logic source_edge_select;
    logic prescaler_assign;
    logic [RATIO_W-1:0] prescale_ratio;
  } option_s;

  // Strobes and data that the core drives toward this block.
  typedef struct packed {
    logic file_wr;
    logic [ADDR_W-1:0] addr;
    logic option_wr;
    logic tris_wr;
    logic [7:0] data;
  } core_wr_s;

  function automatic logic rose(input logic prev, input logic cur);
    return cur & ~prev;
  endfunction

endpackage

// ### pin_sync.sv
`timescale 1ns/1ps
module pin_sync
  import tmr_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  // Asynchronous level and its synchronised copy.
  input wire logic async_in,
  output logic sync_out
);

  typedef struct packed {
    logic meta;
    logic stable;
  } sync_state_s;

  sync_state_s q;
  sync_state_s d;

  always_comb begin
    d.meta = async_in;
    d.stable = q.meta;
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sync_out = q.stable;

endmodule

// ### prescaler_counter.sv
`timescale 1ns/1ps
module prescaler_counter
  import tmr_pkg::*;
#(
  parameter int WIDTH = PRESC_W
)
(
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  // Count control.
  input wire logic clear_in,
  input wire logic tick_in,
  input wire logic [RATIO_W-1:0] ratio_in,
  // Divided outputs.
  output logic tap_out,
  output logic post_out
);

  if (WIDTH < (1 << RATIO_W)) begin : g_width_check
    $error("prescaler_counter: WIDTH too small for the ratio field");
  end

  typedef struct packed {
    logic [WIDTH-1:0] cnt;
  } presc_state_s;

  presc_state_s q;
  presc_state_s d;
  logic [WIDTH-1:0] mask;

  always_comb begin
    d = q;
    mask = WIDTH'((1 << ratio_in) - 1);
    // Timer tap: 000 gives 1:2 up to 111 for 1:256.
    tap_out = q.cnt[ratio_in];
    // Watchdog postscale: 000 gives 1:1 up to 111 for 1:128.
    post_out = tick_in & ((q.cnt & mask) == mask);
    if (clear_in) begin
      d.cnt = PRESC_RESET;
    end else if (tick_in) begin
      d.cnt = q.cnt + WIDTH'(1);
    end
  end

  // Software has no path to the count; only reset and clear reach it.
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      q.cnt <= PRESC_RESET;
    end else begin
      q <= d;
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);

  clear_zero_a: assert property (clear_in |=> q.cnt == '0)
    else $error("prescaler not cleared");

  wdt_unity_a: assert property (
    tick_in && ratio_in == 3'h0 |-> post_out)
    else $error("1:1 postscale missed a tick");

endmodule

// ### timer_counter_top.sv
`timescale 1ns/1ps
module timer_counter_top
  import tmr_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  // Core register writes and instructions.
  input wire core_wr_s core_wr_in,
  input wire logic watchdog_clear_in,
  // Watchdog oscillator overflow, one pulse per period.
  input wire logic watchdog_tick_in,
  // External timer clock pin.
  input wire logic timer_clock_pin_in,
  // Register contents and status.
  output logic [TIMER_W-1:0] timer_count_out,
  output option_s option_out,
  output logic [TRIS_W-1:0] pin_oe_out,
  // Watchdog timeout, after the postscaler only when the prescaler is assigned to the watchdog.
  output logic watchdog_timeout_out
);

  typedef struct packed {
    logic [1:0] phase;
    logic [TIMER_W-1:0] timer;
    option_s opt;
    logic [TRIS_W-1:0] tris;
    logic [3:0] inhibit;
    logic src_prev;
    logic sample;
    logic wdt_out;
    logic [TRIS_W-1:0] pin_oe;
  } state_s;

  state_s q;
  state_s d;

  logic pin_level;
  logic src;
  logic src_edge;
  logic instr_tick;
  logic to_timer;
  logic timer_write;
  logic presc_tick;
  logic presc_clear;
  logic presc_tap;
  logic presc_post;
  logic sync_src;
  logic sample_pt;
  logic sampled_rise;
  logic inc;

  // The pin is asynchronous to the oscillator and is brought in first.
  pin_sync u_pin_sync (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .async_in(timer_clock_pin_in),
    .sync_out(pin_level)
  );

  prescaler_counter #(
    .WIDTH(PRESC_W)
  ) u_prescaler (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .clear_in(presc_clear),
    .tick_in(presc_tick),
    .ratio_in(q.opt.prescale_ratio),
    .tap_out(presc_tap),
    .post_out(presc_post)
  );

  always_comb begin
    d = q;
    d.phase = q.phase + 2'h1;

    // A set edge select inverts the pin, so falling edges rise here.
    src = pin_level ^ q.opt.source_edge_select;
    src_edge = rose(q.src_prev, src);
    d.src_prev = src;

    instr_tick = (q.phase == PHASE_Q4);
    to_timer = ~q.opt.prescaler_assign;
    timer_write = core_wr_in.file_wr &&
                  (core_wr_in.addr == TIMER_COUNT_ADDR);

    // One counter, steered by the assign bit alone.
    if (to_timer) begin
      presc_tick = q.opt.clock_source_select ? src_edge : instr_tick;
      presc_clear = timer_write;
    end else begin
      presc_tick = watchdog_tick_in;
      presc_clear = watchdog_clear_in;
    end

    // With no prescaler the pin itself is the prescaler output.
    sync_src = to_timer ? presc_tap : src;
    sample_pt = (q.phase == PHASE_Q2) || (q.phase == PHASE_Q4);
    sampled_rise = sample_pt && rose(q.sample, sync_src);
    if (sample_pt) begin
      d.sample = sync_src;
    end

    if (!q.opt.clock_source_select && !to_timer) begin
      inc = instr_tick;
    end else begin
      inc = sampled_rise;
    end

    // A write beats an increment and starts the hold-off.
    if (timer_write) begin
      d.timer = core_wr_in.data;
      d.inhibit = INHIBIT_CLKS;
    end else if (q.inhibit != 4'h0) begin
      d.inhibit = q.inhibit - 4'h1;
    end else if (inc) begin
      d.timer = q.timer + 8'h01;
    end

    if (core_wr_in.option_wr) begin
      d.opt = option_s'(core_wr_in.data);
    end
    if (core_wr_in.tris_wr) begin
      d.tris = core_wr_in.data[TRIS_W-1:0];
    end

    // Enable is the inverse of the direction latch; counter mode holds the clock pin off.
    d.pin_oe = ~d.tris;
    if (d.opt.clock_source_select) begin
      d.pin_oe[PIN_CLK_IDX] = 1'b0;
    end

    // The watchdog sees its own ticks undivided when not assigned.
    d.wdt_out = to_timer ? watchdog_tick_in : presc_post;
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      q.phase <= PHASE_Q1;
      q.timer <= TIMER_RESET;
      q.opt <= option_s'(OPTION_RESET);
      q.tris <= TRIS_RESET;
      q.inhibit <= 4'h0;
      q.src_prev <= 1'b0;
      q.sample <= 1'b0;
      q.wdt_out <= 1'b0;
      q.pin_oe <= 4'h0;
    end else begin
      q <= d;
    end
  end

  assign timer_count_out = q.timer;
  assign option_out = q.opt;
  assign pin_oe_out = q.pin_oe;
  assign watchdog_timeout_out = q.wdt_out;

  // Checks on the finished behaviour.
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);

  logic timer_direct;
  logic counter_direct;
  assign timer_direct = !q.opt.clock_source_select &&
                        q.opt.prescaler_assign;
  assign counter_direct = q.opt.clock_source_select &&
                          q.opt.prescaler_assign;

  write_load_a: assert property (
    timer_write |=> q.timer == $past(core_wr_in.data) &&
                    q.inhibit == INHIBIT_CLKS)
    else $error("timer write not loaded with hold-off");

  hold_off_a: assert property (
    q.inhibit != 4'h0 && !timer_write |=> $stable(q.timer))
    else $error("timer moved during hold-off");

  hold_len_a: assert property (
    timer_write ##1 (!timer_write)[*8] |=> q.inhibit == 4'h0)
    else $error("hold-off not two instruction cycles");

  timer_tick_a: assert property (
    timer_direct && q.phase == PHASE_Q4 && q.inhibit == 4'h0 &&
    !timer_write && !core_wr_in.option_wr
    |=> q.timer == $past(q.timer) + 8'h01)
    else $error("timer mode missed its instruction cycle");

  timer_idle_a: assert property (
    timer_direct && q.phase != PHASE_Q4 && !timer_write
    |=> $stable(q.timer))
    else $error("timer mode counted off the cycle boundary");

  wrap_a: assert property (
    q.timer == 8'hFF && inc && q.inhibit == 4'h0 && !timer_write
    |=> q.timer == 8'h00)
    else $error("count did not wrap to zero");

  edge_sample_a: assert property (
    counter_direct && src_edge && !core_wr_in.option_wr
    ##1 (counter_direct && src) [*2]
    |-> q.sample)
    else $error("pin edge not sampled within two clocks");

  counter_idle_a: assert property (
    counter_direct && !sample_pt && !timer_write
    |=> $stable(q.timer))
    else $error("counter mode stepped without a sample");

  pin_override_a: assert property (
    q.opt.clock_source_select |-> !pin_oe_out[PIN_CLK_IDX])
    else $error("timer pin driven in counter mode");

  presc_clear_a: assert property (
    (to_timer && timer_write) || (!to_timer && watchdog_clear_in)
    |-> presc_clear)
    else $error("prescaler clear not raised");

  wdt_gate_a: assert property (
    to_timer && !watchdog_tick_in |=> !watchdog_timeout_out)
    else $error("watchdog pulse while prescaler on timer");

  option_load_a: assert property (
    core_wr_in.option_wr |=> option_out == $past(core_wr_in.data))
    else $error("option write not taken");

  timer_wrap_c: cover property (
    q.timer == 8'hFF ##1 q.timer == 8'h00);

  counter_step_c: cover property (
    counter_direct && sampled_rise ##1 q.timer != $past(q.timer));

  prescaled_step_c: cover property (
    to_timer && inc && q.inhibit == 4'h0);

  wdt_timeout_c: cover property (
    !to_timer && watchdog_timeout_out);

endmodule

// ### ext_clock_source.sv
`timescale 1ns/1ps
module ext_clock_source (
  // Clock and burst control.
  input wire logic clk_sys_in,
  input wire logic run_in,
  input wire logic [7:0] half_in,
  // Timer clock pin level.
  output logic pin_out
);
  logic [7:0] cnt_q;

  // Between bursts the pin rests low, so no stray edge reaches the counter.
  always_ff @(posedge clk_sys_in) begin
    if (!run_in) begin
      cnt_q <= 8'h00;
      pin_out <= 1'b0;
    end else if (cnt_q == half_in - 8'h01) begin
      cnt_q <= 8'h00;
      pin_out <= ~pin_out;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule

// ### tb_eight_bit_timer_with_prescaler.sv
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin bad_count++; \
  $display("CHECK FAILED %0t got %0h exp %0h", $time, a, e); end end
module tb_eight_bit_timer_with_prescaler;
  import tmr_pkg::*;
  logic clk_sys_in, resetn_in, wd_clr, wd_tick, run, tmo;
  logic [7:0] half, count;
  logic [3:0] oe;
  wire logic pin;
  core_wr_s core_wr;
  option_s opt;
  int cmp_count, bad_count, rises, falls, tmo_cnt;

  timer_counter_top DUT (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
    .core_wr_in(core_wr), .watchdog_clear_in(wd_clr),
    .watchdog_tick_in(wd_tick), .timer_clock_pin_in(pin),
    .timer_count_out(count), .option_out(opt), .pin_oe_out(oe),
    .watchdog_timeout_out(tmo));
  ext_clock_source src (.clk_sys_in(clk_sys_in), .run_in(run),
    .half_in(half), .pin_out(pin));

  always #2.5 clk_sys_in = ~clk_sys_in;
  always @(posedge pin) rises++;
  always @(negedge pin) falls++;
  always @(posedge clk_sys_in) if (tmo === 1'b1) tmo_cnt++;

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Kind 0 writes the file register, 1 the option, 2 the direction latch.
  task automatic wr(input int k, input logic [ADDR_W-1:0] a,
                    input logic [7:0] d);
    @(negedge clk_sys_in);
    core_wr = '{file_wr: k == 0, addr: a, option_wr: k == 1,
                tris_wr: k == 2, data: d};
    @(negedge clk_sys_in);
    core_wr = '0;
  endtask

  // Returns the cycles until the count moves; a stuck count ends the run.
  task automatic wait_chg(input int lim, output int n);
    logic [7:0] v;
    v = count;
    n = 0;
    while (count === v && n < lim) begin
      @(negedge clk_sys_in);
      n++;
    end
    if (n >= lim) begin
      `CHK(1'b0, 1'b1)
      results();
    end
  endtask

  task automatic pulse_clr();
    @(negedge clk_sys_in);
    wd_clr = 1'b1;
    @(negedge clk_sys_in);
    wd_clr = 1'b0;
  endtask

  task automatic tick(input int m);
    repeat (m) begin
      @(negedge clk_sys_in);
      wd_tick = 1'b1;
      @(negedge clk_sys_in);
      wd_tick = 1'b0;
      repeat (2) @(negedge clk_sys_in);
    end
  endtask

  task automatic t_timer();
    int n;
    wr(2, 0, 8'h00);
    wr(1, 0, 8'hC8);
    `CHK(oe, 4'hF)
    wr(0, TIMER_COUNT_ADDR, 8'hFD);
    `CHK(count, 8'hFD)
    repeat (6) @(negedge clk_sys_in);
    `CHK(count, 8'hFD)
    wait_chg(8, n);
    `CHK(count, 8'hFE)
    wait_chg(8, n);
    `CHK(n, 4)
    wait_chg(8, n);
    `CHK(count, 8'h00)
    wr(0, 5'h02, 8'h55);
    `CHK(count == 8'h55, 1'b0)
  endtask

  task automatic t_ratio();
    int n;
    // Leaving the watchdog: clear it before the assignment moves.
    pulse_clr();
    for (int r = 0; r < 8; r++) begin
      wr(1, 0, {5'b11000, 3'(r)});
      wr(0, TIMER_COUNT_ADDR, 8'h00);
      wait_chg(1100, n);
      wait_chg(1100, n);
      `CHK(n, 8 << r)
    end
    // A quarter of the way through a 1:256 period, so a kept prescaler shows late.
    repeat (250) @(negedge clk_sys_in);
    wr(0, TIMER_COUNT_ADDR, 8'h10);
    wait_chg(1100, n);
    `CHK(n > 480 && n < 640, 1'b1)
  endtask

  task automatic t_count(input logic se, input logic pa);
    int n, e0, exp;
    logic [7:0] c0;
    // Safe switch order in both directions of assignment.
    pulse_clr();
    wr(0, TIMER_COUNT_ADDR, 8'h00);
    wr(1, 0, {3'b111, se, pa, 3'b000});
    `CHK(oe, 4'hB)
    wr(0, TIMER_COUNT_ADDR, 8'h00);
    repeat (12) @(negedge clk_sys_in);
    c0 = count;
    e0 = se ? falls : rises;
    run = 1'b1;
    if (!se && pa) begin
      for (n = 0; n < 20 && pin !== 1'b1; n++) @(negedge clk_sys_in);
      wait_chg(10, n);
      `CHK(n >= 3 && n <= 7, 1'b1)
    end
    repeat (96) @(negedge clk_sys_in);
    run = 1'b0;
    repeat (12) @(negedge clk_sys_in);
    exp = (se ? falls : rises) - e0;
    if (!pa) exp = (exp + 1) / 2;
    `CHK(count - c0, 8'(exp))
  endtask

  task automatic t_wdog();
    int t0;
    pulse_clr();
    wr(0, TIMER_COUNT_ADDR, 8'h00);
    for (int r = 0; r < 8; r++) begin
      wr(1, 0, {5'b11001, 3'(r)});
      pulse_clr();
      t0 = tmo_cnt;
      tick(2 << r);
      `CHK(tmo_cnt - t0, 2)
    end
    wr(1, 0, 8'hCA);
    pulse_clr();
    tick(2);
    t0 = tmo_cnt;
    pulse_clr();
    tick(2);
    `CHK(tmo_cnt - t0, 0)
    pulse_clr();
    wr(1, 0, 8'hC2);
    t0 = tmo_cnt;
    tick(3);
    `CHK(tmo_cnt - t0, 3)
  endtask

  initial begin
    clk_sys_in = 1'b0;
    resetn_in = 1'b0;
    core_wr = '0;
    wd_clr = 1'b0;
    wd_tick = 1'b0;
    run = 1'b0;
    half = 8'h03;
    repeat (3) @(negedge clk_sys_in);
    `CHK(count, TIMER_RESET)
    `CHK(opt, OPTION_RESET)
    `CHK(oe, 4'h0)
    `CHK(tmo, 1'b0)
    resetn_in = 1'b1;
    @(negedge clk_sys_in);
    t_timer();
    t_ratio();
    t_count(1'b0, 1'b1);
    t_count(1'b1, 1'b1);
    t_count(1'b0, 1'b0);
    t_count(1'b1, 1'b0);
    t_wdog();
    results();
  end
endmodule
